// ==== rtl/uvfr_top.sv ====
// Input undervoltage fault response controller with its command registers.
`timescale 1ns/1ps
`include "uvfr_params.svh"

module uvfr_top (
  input wire logic CLOCK, // System clock, 200 MHz.
  input wire logic SRST, // Synchronous reset, active high.
  input wire uvfr_pkg::uvfr_req_t REG_REQ, // Decoded command access.
  output logic [15:0] REG_RDATA, // Read data.
  output logic REG_ACK, // Access accepted pulse.
  output logic REG_NAK, // Access refused pulse.
  input wire logic [15:0] VIN_MEAS, // Measured input voltage code.
  input wire logic CTRL_PIN, // Remote on/off pin, high means on.
  input wire logic FAULT_RESET_PIN, // Fault reset pin, active high.
  input wire logic OTHER_SHUTDOWN, // Shutdown from another fault.
  output logic OUTPUT_ENABLE, // Converter output enable.
  output logic UV_FAULT, // Sticky undervoltage status.
  output logic LATCHED_OFF, // Output latched off.
  output logic RETRY_ACTIVE // Restart sequence running.
);

  import uvfr_pkg::*;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic ctrl_on;
  logic ext_reset;

  uvfr_sync u_ctrl_sync (
    .clock(CLOCK),
    .srst(SRST),
    .async_in(CTRL_PIN),
    .sync_out(ctrl_on)
  );

  uvfr_sync u_reset_sync (
    .clock(CLOCK),
    .srst(SRST),
    .async_in(FAULT_RESET_PIN),
    .sync_out(ext_reset)
  );

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic code_mapped(input logic [7:0] code);
    code_mapped = (code == `UVFR_CMD_OPERATION) || (code == `UVFR_CMD_CLEAR_FAULTS) ||
                  (code == `UVFR_CMD_UV_THRESHOLD) || (code == `UVFR_CMD_UV_ACTION) ||
                  (code == `UVFR_CMD_STATUS_INPUT) || (code == `UVFR_CMD_TIME_UNIT);
  endfunction : code_mapped

  function automatic logic retries_spent(input logic [2:0] limit, input logic [2:0] done_cnt);
    retries_spent = (limit != `UVFR_RETRY_FOREVER) && (done_cnt >= limit);
  endfunction : retries_spent

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [7:0] operation;
  logic [15:0] uv_threshold;
  uvfr_action_t action;
  logic [15:0] time_unit;
  logic uv_sticky;

  logic wr_hit;
  logic clear_faults;
  logic status_clear;
  logic fault_clear;

  assign wr_hit = REG_REQ.wr && !REG_REQ.rd;
  assign clear_faults = wr_hit && (REG_REQ.code == `UVFR_CMD_CLEAR_FAULTS);
  assign status_clear = wr_hit && (REG_REQ.code == `UVFR_CMD_STATUS_INPUT) &&
                        REG_REQ.wdata[`UVFR_STS_UV_FAULT_BIT];
  assign fault_clear = clear_faults || status_clear || ext_reset;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      operation <= `UVFR_OPERATION_RST;
    end else if (wr_hit && (REG_REQ.code == `UVFR_CMD_OPERATION)) begin
      operation <= REG_REQ.wdata[7:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      uv_threshold <= `UVFR_UV_THRESHOLD_RST;
    end else if (wr_hit && (REG_REQ.code == `UVFR_CMD_UV_THRESHOLD)) begin
      uv_threshold <= REG_REQ.wdata;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      action <= uvfr_action_t'(`UVFR_UV_ACTION_RST);
    end else if (wr_hit && (REG_REQ.code == `UVFR_CMD_UV_ACTION)) begin
      action <= uvfr_action_t'(REG_REQ.wdata[7:0]);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      time_unit <= `UVFR_TIME_UNIT_RST;
    end else if (wr_hit && (REG_REQ.code == `UVFR_CMD_TIME_UNIT)) begin
      time_unit <= REG_REQ.wdata;
    end
  end

  // --------------------------------------------------------------------------
  // Fault detection and sticky status
  // --------------------------------------------------------------------------
  logic uv_now;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      uv_now <= 1'b0;
    end else begin
      uv_now <= (VIN_MEAS < uv_threshold);
    end
  end

  // A fault present in the clearing cycle keeps the bit set.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      uv_sticky <= 1'b0;
    end else if (uv_now) begin
      uv_sticky <= 1'b1;
    end else if (fault_clear) begin
      uv_sticky <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Register read and access answer
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      REG_ACK <= 1'b0;
      REG_NAK <= 1'b0;
      REG_RDATA <= 16'h0000;
    end else begin
      REG_ACK <= 1'b0;
      REG_NAK <= 1'b0;
      if (REG_REQ.rd) begin
        REG_ACK <= code_mapped(REG_REQ.code) && (REG_REQ.code != `UVFR_CMD_CLEAR_FAULTS);
        REG_NAK <= !code_mapped(REG_REQ.code) || (REG_REQ.code == `UVFR_CMD_CLEAR_FAULTS);
        if (REG_REQ.code == `UVFR_CMD_OPERATION) begin
          REG_RDATA <= {8'h00, operation};
        end else if (REG_REQ.code == `UVFR_CMD_UV_THRESHOLD) begin
          REG_RDATA <= uv_threshold;
        end else if (REG_REQ.code == `UVFR_CMD_UV_ACTION) begin
          REG_RDATA <= {8'h00, action};
        end else if (REG_REQ.code == `UVFR_CMD_STATUS_INPUT) begin
          REG_RDATA <= 16'(uv_sticky) << `UVFR_STS_UV_FAULT_BIT;
        end else if (REG_REQ.code == `UVFR_CMD_TIME_UNIT) begin
          REG_RDATA <= time_unit;
        end else begin
          REG_RDATA <= 16'h0000;
        end
      end else if (REG_REQ.wr) begin
        REG_ACK <= code_mapped(REG_REQ.code);
        REG_NAK <= !code_mapped(REG_REQ.code);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Delay timer
  // --------------------------------------------------------------------------
  logic cmd_on;
  logic stop_now;
  logic tmr_start;
  logic tmr_done;

  assign cmd_on = ctrl_on && operation[`UVFR_OP_ON_BIT];
  assign stop_now = !cmd_on || OTHER_SHUTDOWN;

  uvfr_delay_timer u_timer (
    .clock(CLOCK),
    .srst(SRST),
    .start(tmr_start),
    .abort(stop_now),
    .units_log2(action.delay_log2),
    .unit_len(time_unit),
    .done(tmr_done)
  );

  // --------------------------------------------------------------------------
  // Response state machine
  // --------------------------------------------------------------------------
  uvfr_state_t state;
  logic [2:0] attempts;

  // Leaving the machine through ST_OFF on a command-off is what releases a latch
  // on an off-then-on sequence, and also ends an endless retry loop.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state <= ST_OFF;
      attempts <= 3'h0;
      tmr_start <= 1'b0;
    end else begin
      tmr_start <= 1'b0;
      if (stop_now) begin
        state <= ST_OFF;
        attempts <= 3'h0;
      end else begin
        case (state)
          ST_OFF: begin
            state <= ST_RUN;
          end
          ST_RUN: begin
            if (uv_now) begin
              case (action.response)
                RESP_IGNORE: begin
                  state <= ST_RUN;
                end
                RESP_RIDE: begin
                  state <= ST_RIDE;
                  tmr_start <= 1'b1;
                end
                RESP_RETRY: begin
                  attempts <= 3'h0;
                  if (action.retries == `UVFR_RETRY_NONE) begin
                    state <= ST_LATCHED;
                  end else begin
                    state <= ST_HOLDOFF;
                    tmr_start <= 1'b1;
                  end
                end
                default: begin
                  state <= ST_LATCHED;
                end
              endcase
            end
          end
          ST_RIDE: begin
            if (tmr_done) begin
              attempts <= 3'h0;
              if (!uv_now) begin
                state <= ST_RUN;
              end else if (action.retries == `UVFR_RETRY_NONE) begin
                state <= ST_LATCHED;
              end else begin
                state <= ST_HOLDOFF;
                tmr_start <= 1'b1;
              end
            end
          end
          ST_HOLDOFF: begin
            if (tmr_done) begin
              state <= ST_ATTEMPT;
              attempts <= 3'h1;
              tmr_start <= 1'b1;
            end
          end
          ST_ATTEMPT: begin
            if (tmr_done) begin
              if (!uv_now) begin
                state <= ST_RUN;
                attempts <= 3'h0;
              end else if (retries_spent(action.retries, attempts)) begin
                state <= ST_LATCHED;
              end else begin
                tmr_start <= 1'b1;
                if (attempts != 3'h7) begin
                  attempts <= attempts + 3'h1;
                end
              end
            end
          end
          ST_LATCHED: begin
            if (fault_clear) begin
              state <= ST_RUN;
              attempts <= 3'h0;
            end
          end
          default: begin
            state <= ST_OFF;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Each attempt opens with one cycle of output off, so a failed attempt is a
  // real restart rather than a continuous on period.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      OUTPUT_ENABLE <= 1'b0;
    end else begin
      OUTPUT_ENABLE <= !stop_now && ((state == ST_RUN) || (state == ST_RIDE) ||
                       ((state == ST_ATTEMPT) && !tmr_start));
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      UV_FAULT <= 1'b0;
      LATCHED_OFF <= 1'b0;
      RETRY_ACTIVE <= 1'b0;
    end else begin
      UV_FAULT <= uv_sticky;
      LATCHED_OFF <= (state == ST_LATCHED);
      RETRY_ACTIVE <= (state == ST_HOLDOFF) || (state == ST_ATTEMPT);
    end
  end

endmodule : uvfr_top

// ==== pkg/uvfr_params.svh ====
// Constants for the input undervoltage fault response block.
`ifndef UVFR_PARAMS_SVH
`define UVFR_PARAMS_SVH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define UVFR_CMD_OPERATION 8'h01
`define UVFR_CMD_CLEAR_FAULTS 8'h03
`define UVFR_CMD_UV_THRESHOLD 8'h59
`define UVFR_CMD_UV_ACTION 8'h5a
`define UVFR_CMD_STATUS_INPUT 8'h7c
`define UVFR_CMD_TIME_UNIT 8'hd2

// ----------------------------------------------------------------------------
// Field positions and retry codes
// ----------------------------------------------------------------------------
`define UVFR_OP_ON_BIT 7
`define UVFR_STS_UV_FAULT_BIT 4
`define UVFR_RETRY_FOREVER 3'h7
`define UVFR_RETRY_NONE 3'h0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define UVFR_OPERATION_RST 8'h80
`define UVFR_UV_THRESHOLD_RST 16'h0000
`define UVFR_UV_ACTION_RST 8'h80
`define UVFR_TIME_UNIT_RST 16'h0001

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define UVFR_CLOCK_MHZ 200
`define UVFR_TICK_NS 1000
`define UVFR_TICK_CYCLES ((`UVFR_TICK_NS * `UVFR_CLOCK_MHZ) / 1000)

`endif

// ==== pkg/uvfr_pkg.sv ====
// Types shared by the input undervoltage fault response block.
package uvfr_pkg;

  typedef enum logic [1:0] {
    RESP_IGNORE,
    RESP_RIDE,
    RESP_RETRY,
    RESP_LATCH
  } uvfr_resp_t;

  typedef struct packed {
    uvfr_resp_t response;
    logic [2:0] retries;
    logic [2:0] delay_log2;
  } uvfr_action_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] wdata;
  } uvfr_req_t;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_RUN,
    ST_RIDE,
    ST_HOLDOFF,
    ST_ATTEMPT,
    ST_LATCHED
  } uvfr_state_t;

endpackage : uvfr_pkg

// ==== rtl/uvfr_sync.sv ====
// Two-stage synchroniser for one asynchronous pin.
`timescale 1ns/1ps

module uvfr_sync (
  input wire logic clock, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic async_in, // Pin from outside the clock domain.
  output logic sync_out // Synchronised level.
);

  logic stage1;

  always_ff @(posedge clock) begin
    if (srst) begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : uvfr_sync

// ==== rtl/uvfr_delay_timer.sv ====
// Delay timer counting 2^n time units of a programmable length.
`timescale 1ns/1ps
`include "uvfr_params.svh"

module uvfr_delay_timer (
  input wire logic clock, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic start, // Pulse that starts a new delay.
  input wire logic abort, // Level that stops the timer.
  input wire logic [2:0] units_log2, // Delay field, 2^n units.
  input wire logic [15:0] unit_len, // Length of one unit in microsecond ticks.
  output logic done // One-cycle pulse at the end of the delay.
);

  localparam logic [7:0] TICK_LAST = 8'(`UVFR_TICK_CYCLES - 1);

  logic busy;
  logic [7:0] tick_cnt;
  logic [22:0] remain;

  always_ff @(posedge clock) begin
    if (srst || abort) begin
      busy <= 1'b0;
      done <= 1'b0;
      tick_cnt <= 8'h00;
      remain <= 23'h000000;
    end else begin
      done <= 1'b0;
      if (start) begin
        remain <= 23'(unit_len) << units_log2;
        tick_cnt <= 8'h00;
        busy <= 1'b1;
      end else if (busy) begin
        if (remain == 23'h000000) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else if (tick_cnt == TICK_LAST) begin
          tick_cnt <= 8'h00;
          remain <= remain - 23'h000001;
        end else begin
          tick_cnt <= tick_cnt + 8'h01;
        end
      end
    end
  end

endmodule : uvfr_delay_timer

// ==== verification/uvfr_monitor.sv ====
// Port checker for the undervoltage fault response controller.
`timescale 1ns/1ps
module uvfr_monitor (
  input wire logic CLOCK, // System clock.
  input wire logic SRST, // Synchronous reset.
  input wire uvfr_pkg::uvfr_req_t REG_REQ, // Register access.
  input wire logic REG_ACK, // Access accepted.
  input wire logic REG_NAK, // Access refused.
  input wire logic [15:0] VIN_MEAS, // Measured input.
  input wire logic CTRL_PIN, // Remote on/off.
  input wire logic FAULT_RESET_PIN, // Fault reset pin.
  input wire logic OTHER_SHUTDOWN, // Other fault.
  input wire logic OUTPUT_ENABLE, // Output enable.
  input wire logic UV_FAULT, // Undervoltage status.
  input wire logic LATCHED_OFF, // Latched off.
  input wire logic RETRY_ACTIVE // Restart sequence.
);
  import uvfr_pkg::*;
  // ------------------------------------------------------------
  // Shadow configuration and event counters
  // ------------------------------------------------------------
  logic [7:0] cfg;
  logic [15:0] thr, tu;
  logic wr, oe_q, rise;
  logic [7:0] rises, since_clr;
  logic [31:0] gap, dly;
  assign wr = REG_REQ.wr && !REG_REQ.rd;
  assign rise = OUTPUT_ENABLE && !oe_q;
  assign dly = tu * (32'h1 << cfg[2:0]) * 32'd200;
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      cfg <= 8'h80;
      thr <= 16'h0000;
      tu <= 16'h0001;
    end else if (wr) begin
      if (REG_REQ.code == 8'h5a) cfg <= REG_REQ.wdata[7:0];
      if (REG_REQ.code == 8'h59) thr <= REG_REQ.wdata;
      if (REG_REQ.code == 8'hd2) tu <= REG_REQ.wdata;
    end
  end
  always_ff @(posedge CLOCK) begin
    oe_q <= OUTPUT_ENABLE;
    gap <= rise ? 32'h1 : gap + 32'h1;
    if (SRST || (!RETRY_ACTIVE && !LATCHED_OFF)) rises <= 8'h00;
    else if (rise) rises <= rises + 8'h01;
  end
  // Any cause that may release a latch restarts this count.
  always_ff @(posedge CLOCK) begin
    if (SRST || FAULT_RESET_PIN || !CTRL_PIN || OTHER_SHUTDOWN || (wr && REG_REQ.code inside {8'h01, 8'h03, 8'h7c}))
      since_clr <= 8'h00;
    else if (since_clr != 8'hff) since_clr <= since_clr + 8'h01;
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SRST);
  a_reg_answer: assert property ((REG_REQ.wr || REG_REQ.rd) |=> REG_ACK != REG_NAK)
    else $error("register access without a single answer");
  a_uv_status: assert property ((VIN_MEAS < thr) [*3] |=> UV_FAULT)
    else $error("undervoltage status not set");
  a_ignore_mode: assert property ($rose(RETRY_ACTIVE) || $rose(LATCHED_OFF) |-> cfg[7:6] != 2'b00)
    else $error("fault acted on in ignore mode");
  a_fast_disable: assert property (cfg[7] && OUTPUT_ENABLE && !RETRY_ACTIVE && VIN_MEAS < thr
    |-> ##[1:4] !OUTPUT_ENABLE)
    else $error("output not disabled on fault");
  a_latch_off: assert property (LATCHED_OFF |-> !OUTPUT_ENABLE)
    else $error("output on while latched");
  a_release_cause: assert property ($fell(LATCHED_OFF) |-> since_clr <= 8'd8)
    else $error("latch released without a clearing action");
  a_retry_count: assert property ($rose(LATCHED_OFF) && cfg[7:6] != 2'b11 |-> rises == {5'h00, cfg[5:3]})
    else $error("wrong number of restarts before latch");
  a_retry_spacing: assert property (rise && RETRY_ACTIVE && rises != 8'h00
    |-> gap + 32'd2 >= dly && gap <= dly + 32'd10)
    else $error("restart spacing wrong");
  a_forever_retry: assert property (cfg[5:3] == 3'h7 && cfg[7:6] != 2'b11 |-> !$rose(LATCHED_OFF))
    else $error("continuous retry latched off");
  c_latch: cover property ($rose(LATCHED_OFF));
  c_release: cover property ($fell(LATCHED_OFF));
  c_restart: cover property (rise && RETRY_ACTIVE);
endmodule : uvfr_monitor

bind uvfr_top uvfr_monitor i_monitor (.CLOCK, .SRST, .REG_REQ, .REG_ACK, .REG_NAK, .VIN_MEAS, .CTRL_PIN,
  .FAULT_RESET_PIN, .OTHER_SHUTDOWN, .OUTPUT_ENABLE, .UV_FAULT, .LATCHED_OFF, .RETRY_ACTIVE);

// ==== verification/uvfr_host.sv ====
// Host model that issues command accesses to the fault response block.
`timescale 1ns/1ps
module uvfr_host (
  input wire logic clock, // System clock.
  output uvfr_pkg::uvfr_req_t req, // Access request.
  input wire logic [15:0] rdata, // Read data.
  input wire logic ack, // Accepted.
  input wire logic nak // Refused.
);
  import uvfr_pkg::*;
  initial req = '0;
  // One-cycle request pulse; the answer is taken one edge after it is driven.
  task automatic access(input logic rd, input logic [7:0] code, input logic [15:0] wdata,
                        output logic [15:0] q, output logic [1:0] ans);
    @(posedge clock);
    #1;
    req = '{wr: !rd, rd: rd, code: code, wdata: wdata};
    @(posedge clock);
    #1;
    req = '0;
    q = rdata;
    ans = {ack, nak};
  endtask : access
endmodule : uvfr_host

// ==== verification/uvfr_bench.sv ====
// Self-checking bench for the undervoltage fault response controller.
`timescale 1ns/1ps
`define CMP(what, exp, got) begin checks++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("Error %s expected %0h seen %0h", what, exp, got); end end
module uvfr_bench;
  import uvfr_pkg::*;
  logic clock, srst, ctrl, frst, oshut, ack, nak, oe, uvf, lat, rty;
  logic [15:0] vin, rdata, q;
  logic [1:0] ans;
  uvfr_req_t req;
  int checks, n_mismatch, cyc, rises, gap;
  uvfr_top i_dut (.CLOCK(clock), .SRST(srst), .REG_REQ(req), .REG_RDATA(rdata), .REG_ACK(ack), .REG_NAK(nak),
    .VIN_MEAS(vin), .CTRL_PIN(ctrl), .FAULT_RESET_PIN(frst), .OTHER_SHUTDOWN(oshut), .OUTPUT_ENABLE(oe),
    .UV_FAULT(uvf), .LATCHED_OFF(lat), .RETRY_ACTIVE(rty));
  uvfr_host i_host (.clock(clock), .req(req), .rdata(rdata), .ack(ack), .nak(nak));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // ------------------------------------------------------------
  // Access and observation tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    i_host.access(1'b0, c, d, q, ans);
    `CMP("write answer", 2'b10, ans)
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [1:0] a, input logic [15:0] d);
    i_host.access(1'b1, c, 16'h0000, q, ans);
    `CMP("read answer", a, ans)
    if (a == 2'b10) `CMP("read data", d, q)
  endtask : rd
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done
  // Counts output restarts and the spacing of the last two until latched or out of time.
  task automatic watch(input int lim);
    int t = 0;
    int last = 0;
    logic p;
    rises = 0;
    gap = 0;
    while (lat !== 1'b1 && t < lim) begin
      p = oe;
      tick(1);
      t++;
      if (oe === 1'b1 && p === 1'b0) begin
        rises++;
        gap = t - last;
        last = t;
      end
    end
  endtask : watch
  task automatic run_retry(input logic [7:0] cfg, input logic [15:0] tu, input int k);
    int d;
    d = tu * (1 << cfg[2:0]) * 200;
    wr(8'hd2, tu);
    wr(8'h5a, {8'h00, cfg});
    vin = 16'h0800;
    watch((k + 2) * (d + 20));
    `CMP("latched", 1'b1, lat)
    `CMP("restarts", k, rises)
    if (k > 1) `CMP("spacing", 1'b1, gap + 2 >= d && gap <= d + 10)
    vin = 16'h2000;
    tick(3);
    wr(8'h7c, 16'h0010);
    tick(10);
  endtask : run_retry
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    srst = 1'b1;
    vin = 16'h2000;
    ctrl = 1'b1;
    frst = 1'b0;
    oshut = 1'b0;
    tick(4);
    srst = 1'b0;
    rd(8'h5a, 2'b10, 16'h0080);
    rd(8'hd2, 2'b10, 16'h0001);
    rd(8'h01, 2'b10, 16'h0080);
    rd(8'h59, 2'b10, 16'h0000);
    rd(8'h03, 2'b01, 16'h0000);
    rd(8'h20, 2'b01, 16'h0000);
    wr(8'h5a, 16'h00a5);
    rd(8'h5a, 2'b10, 16'h00a5);
    wr(8'h59, 16'h1000);
    done("registers");
    wr(8'h5a, 16'h0000);
    vin = 16'h0800;
    tick(300);
    `CMP("ignore output", 1'b1, oe)
    `CMP("ignore restart", 1'b0, rty | lat)
    `CMP("status output", 1'b1, uvf)
    rd(8'h7c, 2'b10, 16'h0010);
    vin = 16'h2000;
    tick(3);
    wr(8'h7c, 16'h0010);
    rd(8'h7c, 2'b10, 16'h0000);
    `CMP("status output clear", 1'b0, uvf)
    done("ignore");
    wr(8'h5a, 16'h00c0);
    for (int m = 0; m < 5; m++) begin
      vin = 16'h0800;
      tick(4);
      `CMP("latch output", 1'b0, oe)
      vin = 16'h2000;
      tick(50);
      `CMP("still latched", 1'b1, lat)
      if (m == 0) wr(8'h7c, 16'h0010);
      if (m == 1) wr(8'h03, 16'h0000);
      if (m == 4) wr(8'h01, 16'h0000);
      frst = (m == 2);
      ctrl = (m != 3);
      tick(10);
      frst = 1'b0;
      ctrl = 1'b1;
      if (m == 4) wr(8'h01, 16'h0080);
      tick(10);
      `CMP("released", 1'b0, lat)
      `CMP("output back", 1'b1, oe)
    end
    done("latch");
    run_retry(8'h80, 16'h0001, 0);
    for (int k = 1; k < 7; k++) run_retry({2'b10, 3'(k), 3'b000}, 16'h0001, k);
    run_retry(8'h93, 16'h0001, 2);
    run_retry(8'h90, 16'h0002, 2);
    run_retry(8'h40, 16'h0001, 0);
    done("retry");
    wr(8'h5a, 16'h0048);
    vin = 16'h0800;
    tick(150);
    `CMP("ride output", 1'b1, oe)
    tick(100);
    `CMP("ride then restart", 1'b1, rty)
    vin = 16'h2000;
    tick(500);
    `CMP("attempt succeeded", 1'b0, rty | lat)
    `CMP("output running", 1'b1, oe)
    done("ride");
    wr(8'h5a, 16'h00b8);
    for (int m = 0; m < 2; m++) begin
      vin = 16'h0800;
      watch(2000);
      `CMP("no latch", 1'b0, lat)
      `CMP("keeps retrying", 1'b1, rises >= 7)
      if (m == 0) ctrl = 1'b0;
      else oshut = 1'b1;
      tick(8);
      `CMP("stopped", 1'b0, oe | rty)
      ctrl = 1'b1;
      oshut = 1'b0;
      vin = 16'h2000;
      tick(10);
    end
    done("continuous");
    give_verdict();
  end
endmodule : uvfr_bench
